// ==== pkg/port_status_regs.vh ====
`ifndef PORT_STATUS_REGS_VH
`define PORT_STATUS_REGS_VH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define ADDR_CONTROL_POLARITY 4'h0
`define ADDR_BUFFER_STATUS 4'h1
`define ADDR_IRQ_STATUS 4'h2
`define ADDR_IRQ_MASK 4'h3
`define ADDR_IN_BUF0 4'h4
`define ADDR_OUT_BUF0 4'h8

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define BIT_IN_ALL_FULL 15
`define BIT_IN_OVERFLOW 14
`define BIT_IN_FULL_LO 8
`define BIT_OUT_ALL_EMPTY 7
`define BIT_OUT_UNDERFLOW 6
`define BIT_OUT_EMPTY_LO 0
`define BIT_BE_POL 2
`define BIT_WR_POL 1
`define BIT_RD_POL 0
`define IRQ_OVERFLOW 0
`define IRQ_UNDERFLOW 1

// ------------------------------------------------------------
// Reset values and mode codes
// ------------------------------------------------------------
`define RST_CONTROL_POLARITY 16'h0000
`define RST_IRQ_MASK 2'h0
`define MODE_MASTER1 2'h3

`endif

// ==== design/byte_slot.v ====
`timescale 1ns/10ps
`include "port_status_regs.vh"

// One byte buffer with a presence flag.
// fill loads data and raises the flag, drain lowers it.
// A fill while the flag is up keeps the stored byte when keep_when_set is high.
module byte_slot #(
    parameter WIDTH = 8,
    parameter FLAG_RESET = 1'b0
) (
    input wire mclk,
    input wire rst,
    input wire fill,
    input wire drain,
    input wire [WIDTH-1:0] fill_data,
    input wire keep_when_set,
    output reg [WIDTH-1:0] data_ff,
    output reg flag_ff
);
    wire take;

    assign take = fill & ~(keep_when_set & flag_ff);

    always @(posedge mclk) begin
        if (rst) begin
            data_ff <= {WIDTH{1'b0}};
            flag_ff <= FLAG_RESET;
        end else begin
            if (take) begin
                data_ff <= fill_data;
            end
            if (fill) begin
                flag_ff <= 1'b1;
            end else if (drain) begin
                flag_ff <= 1'b0;
            end
        end
    end
endmodule

// ==== design/strobe_polarity.v ====
`timescale 1ns/10ps
`include "port_status_regs.vh"

// Applies polarity settings to the strobe and byte-enable pins.
// A pin carrying an address line passes the address untouched.
module strobe_polarity (
    input wire [1:0] port_mode_select,
    input wire byte_enable_polarity,
    input wire write_polarity,
    input wire read_polarity,
    input wire be_active,
    input wire wr_active,
    input wire rd_active,
    input wire be_is_addr,
    input wire wr_is_addr,
    input wire rd_is_addr,
    input wire be_addr,
    input wire wr_addr,
    input wire rd_addr,
    output wire byte_enable_pin,
    output wire write_strobe_pin,
    output wire enable_strobe_pin,
    output wire read_strobe_pin,
    output wire wr_pin_level,
    output wire rd_pin_level
);
    wire master1;
    wire be_lvl;
    wire wr_lvl;
    wire rd_lvl;

    assign master1 = (port_mode_select == `MODE_MASTER1);
    assign be_lvl = byte_enable_polarity ? be_active : ~be_active;
    assign wr_lvl = write_polarity ? wr_active : ~wr_active;
    assign rd_lvl = read_polarity ? rd_active : ~rd_active;
    assign byte_enable_pin = be_is_addr ? be_addr : be_lvl;
    assign wr_pin_level = wr_is_addr ? wr_addr : wr_lvl;
    assign rd_pin_level = rd_is_addr ? rd_addr : rd_lvl;
    // master mode 1 uses enable strobe
    assign write_strobe_pin = master1 ? ~write_polarity : wr_pin_level;
    assign enable_strobe_pin = master1 ? wr_pin_level : ~write_polarity;
    assign read_strobe_pin = rd_pin_level;
endmodule

// ==== design/parallel_port_status_polarity.v ====
`timescale 1ns/10ps
`include "port_status_regs.vh"

// Operation
// - Input all-full when every input buffer full
// - Write to full input sets overflow
// - Per input full flag, cleared by read
// - Output all-empty when every output empty
// - Read of empty output sets underflow
// - Per output empty flag, cleared by write
// - Unused status bits read zero
// - Byte enable polarity from setting
// - Write strobe polarity in slave/master2
// - Master mode 1 uses enable strobe
// - Read strobe polarity in slave/master2
// - Master mode 1 direction strobe polarity
// - Address pins ignore polarity settings
module parallel_port_status_polarity #(
    parameter NBUF = 4,
    parameter WIDTH = 8
) (
    input wire mclk,
    input wire rst,
    input wire [3:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata_ff,
    input wire [1:0] port_mode_select,
    input wire [1:0] ext_sel,
    input wire ext_wr,
    input wire ext_rd,
    input wire [WIDTH-1:0] ext_wdata,
    output reg [WIDTH-1:0] ext_rdata_ff,
    input wire be_active,
    input wire wr_active,
    input wire rd_active,
    input wire be_is_addr,
    input wire wr_is_addr,
    input wire rd_is_addr,
    input wire be_addr,
    input wire wr_addr,
    input wire rd_addr,
    output wire byte_enable_pin,
    output wire write_strobe_pin,
    output wire enable_strobe_pin,
    output wire read_strobe_pin,
    output wire irq
);
    reg [2:0] control_ff;
    reg input_overflow_ff;
    reg output_underflow_ff;
    reg [1:0] irq_status_ff;
    reg [1:0] irq_mask_ff;
    reg [15:0] nxt_rdata;
    wire [NBUF-1:0] input_buffer_full_flags;
    wire [NBUF-1:0] output_buffer_empty_flags;
    wire [NBUF*WIDTH-1:0] in_data;
    wire [NBUF*WIDTH-1:0] out_data;
    wire input_all_full;
    wire output_all_empty;
    wire ovf_evt;
    wire unf_evt;
    wire [15:0] status_word;
    wire [1:0] events;
    wire [15:0] control_reset;
    wire wr_control;
    wire wr_status;
    wire wr_irq_status;
    wire wr_irq_mask;
    wire clr_overflow;
    wire clr_underflow;
    wire sel_in_full;
    wire sel_out_empty;
    wire [WIDTH-1:0] in_rd_byte;
    wire [WIDTH-1:0] out_rd_byte;
    wire [WIDTH-1:0] ext_rd_byte;
    wire [1:0] irq_pending;
    // Next-state values
    reg nxt_input_overflow;
    reg nxt_output_underflow;
    reg [1:0] nxt_irq_status;

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    // Upper bits of the reset word belong to unimplemented control bits
    assign control_reset = `RST_CONTROL_POLARITY;
    assign wr_control = reg_wr & (reg_addr == `ADDR_CONTROL_POLARITY);
    assign wr_status = reg_wr & (reg_addr == `ADDR_BUFFER_STATUS);
    assign wr_irq_status = reg_wr & (reg_addr == `ADDR_IRQ_STATUS);
    assign wr_irq_mask = reg_wr & (reg_addr == `ADDR_IRQ_MASK);
    // Writing zero clears a sticky flag and writing one keeps it,
    // so a read-modify-write of the status word keeps every flag that it read as set
    assign clr_overflow = wr_status & ~reg_wdata[`BIT_IN_OVERFLOW];
    assign clr_underflow = wr_status & ~reg_wdata[`BIT_OUT_UNDERFLOW];

    // ------------------------------------------------------------
    // Byte buffers
    // ------------------------------------------------------------
    // A host write that meets a software read of the same full buffer
    // is refused and counted as overflow; the flag stays up, so the
    // drained byte may be read a second time
    genvar g;
    generate
        for (g = 0; g < NBUF; g = g + 1) begin : buf_gen
            wire ext_hit_wr;
            wire ext_hit_rd;
            wire sw_rd_in;
            wire sw_wr_out;
            assign ext_hit_wr = ext_wr & (ext_sel == g);
            assign ext_hit_rd = ext_rd & (ext_sel == g);
            assign sw_rd_in = reg_rd & (reg_addr == `ADDR_IN_BUF0 + g);
            assign sw_wr_out = reg_wr & (reg_addr == `ADDR_OUT_BUF0 + g);
            // full flag set by host write, cleared by software read
            // full buffer keeps its byte on overflow
            byte_slot #(.WIDTH(WIDTH), .FLAG_RESET(1'b0)) in_slot (
                .mclk(mclk),
                .rst(rst),
                .fill(ext_hit_wr),
                .drain(sw_rd_in),
                .fill_data(ext_wdata),
                .keep_when_set(1'b1),
                .data_ff(in_data[g*WIDTH +: WIDTH]),
                .flag_ff(input_buffer_full_flags[g])
            );
            // empty flag cleared by software write, set when host reads
            // underflow read leaves flag set (fill of empty is idempotent)
            byte_slot #(.WIDTH(WIDTH), .FLAG_RESET(1'b1)) out_slot (
                .mclk(mclk),
                .rst(rst),
                .fill(ext_hit_rd),
                .drain(sw_wr_out),
                .fill_data({WIDTH{1'b0}}),
                .keep_when_set(1'b1),
                .data_ff(),
                .flag_ff(output_buffer_empty_flags[g])
            );
            reg [WIDTH-1:0] out_byte_ff;
            always @(posedge mclk) begin
                if (rst) begin
                    out_byte_ff <= {WIDTH{1'b0}};
                end else if (sw_wr_out) begin
                    out_byte_ff <= reg_wdata[WIDTH-1:0];
                end
            end
            assign out_data[g*WIDTH +: WIDTH] = out_byte_ff;
        end
    endgenerate

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    // aggregate input full
    assign input_all_full = &input_buffer_full_flags;
    assign output_all_empty = &output_buffer_empty_flags;
    // Flags of the buffer that the host addresses this cycle
    assign sel_in_full = input_buffer_full_flags[ext_sel];
    assign sel_out_empty = output_buffer_empty_flags[ext_sel];
    assign ovf_evt = ext_wr & sel_in_full;
    assign unf_evt = ext_rd & sel_out_empty;
    assign events = {unf_evt, ovf_evt};

    // Set wins over a software clear in the same cycle
    always @* begin
        nxt_input_overflow = input_overflow_ff;
        nxt_output_underflow = output_underflow_ff;
        if (ovf_evt) begin
            nxt_input_overflow = 1'b1;
        end else if (clr_overflow) begin
            nxt_input_overflow = 1'b0;
        end
        if (unf_evt) begin
            nxt_output_underflow = 1'b1;
        end else if (clr_underflow) begin
            nxt_output_underflow = 1'b0;
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            input_overflow_ff <= 1'b0;
            output_underflow_ff <= 1'b0;
        end else begin
            input_overflow_ff <= nxt_input_overflow;
            output_underflow_ff <= nxt_output_underflow;
        end
    end

    assign status_word[`BIT_IN_ALL_FULL] = input_all_full;
    assign status_word[`BIT_IN_OVERFLOW] = input_overflow_ff;
    assign status_word[13:12] = 2'b00;
    assign status_word[`BIT_IN_FULL_LO +: 4] = input_buffer_full_flags[3:0];
    assign status_word[`BIT_OUT_ALL_EMPTY] = output_all_empty;
    assign status_word[`BIT_OUT_UNDERFLOW] = output_underflow_ff;
    assign status_word[5:4] = 2'b00;
    assign status_word[`BIT_OUT_EMPTY_LO +: 4] = output_buffer_empty_flags[3:0];

    // ------------------------------------------------------------
    // Control and interrupt registers
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        if (rst) begin
            control_ff <= control_reset[2:0];
        end else if (wr_control) begin
            control_ff <= reg_wdata[2:0];
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            irq_mask_ff <= `RST_IRQ_MASK;
        end else if (wr_irq_mask) begin
            irq_mask_ff <= reg_wdata[1:0];
        end
    end

    // ------------------------------------------------------------
    // Interrupt status
    // ------------------------------------------------------------
    // Write-one-to-clear; a new event in the same cycle survives
    always @* begin
        if (wr_irq_status) begin
            nxt_irq_status = (irq_status_ff & ~reg_wdata[1:0]) | events;
        end else begin
            nxt_irq_status = irq_status_ff | events;
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            irq_status_ff <= 2'h0;
        end else begin
            irq_status_ff <= nxt_irq_status;
        end
    end

    // Level output, so an event that waited masked fires once unmasked
    assign irq_pending = irq_status_ff & irq_mask_ff;
    assign irq = |irq_pending;

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Buffer bytes picked by the low index bits for a register read
    assign in_rd_byte = in_data[reg_addr[1:0]*WIDTH +: WIDTH];
    assign out_rd_byte = out_data[reg_addr[1:0]*WIDTH +: WIDTH];
    // The host read returns the stored byte even on underflow
    assign ext_rd_byte = out_data[ext_sel*WIDTH +: WIDTH];

    always @* begin
        nxt_rdata = 16'h0000;
        case (reg_addr)
            `ADDR_CONTROL_POLARITY: nxt_rdata = {13'h0000, control_ff};
            `ADDR_BUFFER_STATUS: nxt_rdata = status_word;
            `ADDR_IRQ_STATUS: nxt_rdata = {14'h0000, irq_status_ff};
            `ADDR_IRQ_MASK: nxt_rdata = {14'h0000, irq_mask_ff};
            4'h4, 4'h5, 4'h6, 4'h7:
                nxt_rdata = {{(16-WIDTH){1'b0}}, in_rd_byte};
            4'h8, 4'h9, 4'hA, 4'hB:
                nxt_rdata = {{(16-WIDTH){1'b0}}, out_rd_byte};
            // Unmapped indices read zero and ignore writes
            default: nxt_rdata = 16'h0000;
        endcase
    end

    // Read data is zero between reads, so a stale word never looks valid
    always @(posedge mclk) begin
        if (rst) begin
            reg_rdata_ff <= 16'h0000;
        end else begin
            reg_rdata_ff <= reg_rd ? nxt_rdata : 16'h0000;
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            ext_rdata_ff <= {WIDTH{1'b0}};
        end else if (ext_rd) begin
            ext_rdata_ff <= ext_rd_byte;
        end
    end

    // ------------------------------------------------------------
    // Pin polarity
    // ------------------------------------------------------------
    // Pins stay combinational: a polarity change reaches them in the
    // cycle after the control write, with no stage in the strobe path
    strobe_polarity pol (
        .port_mode_select(port_mode_select),
        .byte_enable_polarity(control_ff[`BIT_BE_POL]),
        .write_polarity(control_ff[`BIT_WR_POL]),
        .read_polarity(control_ff[`BIT_RD_POL]),
        .be_active(be_active),
        .wr_active(wr_active),
        .rd_active(rd_active),
        .be_is_addr(be_is_addr),
        .wr_is_addr(wr_is_addr),
        .rd_is_addr(rd_is_addr),
        .be_addr(be_addr),
        .wr_addr(wr_addr),
        .rd_addr(rd_addr),
        .byte_enable_pin(byte_enable_pin),
        .write_strobe_pin(write_strobe_pin),
        .enable_strobe_pin(enable_strobe_pin),
        .read_strobe_pin(read_strobe_pin),
        .wr_pin_level(),
        .rd_pin_level()
    );
endmodule

// ==== sim/port_monitor.sv ====
`timescale 1ns/10ps
`include "port_status_regs.vh"

module port_monitor (
    input logic mclk,
    input logic rst,
    input logic [3:0] reg_addr,
    input logic [15:0] reg_wdata,
    input logic reg_wr,
    input logic reg_rd,
    input logic [15:0] reg_rdata_ff,
    input logic [1:0] port_mode_select,
    input logic be_active,
    input logic wr_active,
    input logic rd_active,
    input logic be_is_addr,
    input logic wr_is_addr,
    input logic rd_is_addr,
    input logic be_addr,
    input logic wr_addr,
    input logic rd_addr,
    input logic byte_enable_pin,
    input logic write_strobe_pin,
    input logic enable_strobe_pin,
    input logic read_strobe_pin
);
    // ------------------------------------------------------------
    // Shadow of the polarity settings, rebuilt from bus writes
    // ------------------------------------------------------------
    logic [2:0] pol_ff;
    wire m1 = port_mode_select == `MODE_MASTER1;

    always @(posedge mclk) begin
        if (rst) begin
            pol_ff <= 3'h0;
        end else if (reg_wr && reg_addr == `ADDR_CONTROL_POLARITY) begin
            pol_ff <= reg_wdata[2:0];
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    sequence stat_rd;
        $past(reg_rd && reg_addr == `ADDR_BUFFER_STATUS);
    endsequence

    a_be_polarity: assert property (
        !be_is_addr |-> byte_enable_pin == (be_active ~^ pol_ff[2])) else $error("be level");
    a_wr_polarity: assert property (
        !m1 && !wr_is_addr |-> write_strobe_pin == (wr_active ~^ pol_ff[1])) else $error("wr");
    a_enable_polarity: assert property (
        m1 && !wr_is_addr |-> enable_strobe_pin == (wr_active ~^ pol_ff[1])) else $error("en");
    a_rd_polarity: assert property (
        !rd_is_addr |-> read_strobe_pin == (rd_active ~^ pol_ff[0])) else $error("rd level");
    a_be_addr_pass: assert property (
        be_is_addr |-> byte_enable_pin == be_addr) else $error("be address");
    a_rd_addr_pass: assert property (
        rd_is_addr |-> read_strobe_pin == rd_addr) else $error("rd address");
    a_wr_addr_pass: assert property (
        wr_is_addr |-> (m1 ? enable_strobe_pin : write_strobe_pin) == wr_addr)
        else $error("wr address");
    a_idle_strobe: assert property (
        (m1 ? write_strobe_pin : enable_strobe_pin) == !pol_ff[1]) else $error("idle strobe");
    a_rdata_idle: assert property (
        !$past(reg_rd) |-> reg_rdata_ff == 16'h0000) else $error("read data not idle");
    a_unused_zero: assert property (
        stat_rd |-> reg_rdata_ff[13:12] == 2'h0 && reg_rdata_ff[5:4] == 2'h0) else $error("unused");
    a_all_full: assert property (
        stat_rd |-> reg_rdata_ff[15] == &reg_rdata_ff[11:8]) else $error("all full");
    a_all_empty: assert property (
        stat_rd |-> reg_rdata_ff[7] == &reg_rdata_ff[3:0]) else $error("all empty");

    c_master1: cover property (m1 && wr_active);
    c_addr_pin: cover property (be_is_addr && rd_is_addr);
    c_overflow: cover property (stat_rd ##0 reg_rdata_ff[14]);
endmodule

// ==== sim/ext_master.sv ====
`timescale 1ns/10ps

// External bus master: writes input buffers, reads output buffers
module ext_master (
    input logic mclk,
    input logic [7:0] ext_rdata_ff,
    output logic [1:0] ext_sel,
    output logic ext_wr,
    output logic ext_rd,
    output logic [7:0] ext_wdata
);
    initial begin
        ext_sel = 2'h0;
        ext_wr = 1'b0;
        ext_rd = 1'b0;
        ext_wdata = 8'h5A;
    end

    task put(input logic [1:0] s, input logic [7:0] d);
        @(posedge mclk);
        ext_sel <= s;
        ext_wdata <= d;
        ext_wr <= 1'b1;
        @(posedge mclk);
        ext_wr <= 1'b0;
        // Released data must not keep showing the byte
        ext_wdata <= ~d;
    endtask

    task get(input logic [1:0] s, output logic [7:0] d);
        @(posedge mclk);
        ext_sel <= s;
        ext_rd <= 1'b1;
        @(posedge mclk);
        ext_rd <= 1'b0;
        #1 d = ext_rdata_ff;
    endtask
endmodule

// ==== sim/tb_top.sv ====
`timescale 1ns/10ps
`include "port_status_regs.vh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; \
    $display("ERROR %s exp %h got %h", nm, e, g); end end

module tb_top;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [1:0] port_mode_select = 2'h0;
    logic [2:0] act = 3'h0;
    logic [2:0] is_addr = 3'h0;
    logic [2:0] abit = 3'h0;
    logic [15:0] reg_rdata, d;
    logic [1:0] ext_sel;
    logic ext_wr, ext_rd, be_pin, wr_pin, en_pin, rd_pin, irq;
    logic [7:0] ext_wdata, ext_rdata, b;
    int errors = 0;
    int n_compared = 0;

    always #50 mclk = ~mclk;

    parallel_port_status_polarity i_parallel_port_status_polarity (.mclk, .rst, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_ff(reg_rdata), .port_mode_select, .ext_sel,
        .ext_wr, .ext_rd, .ext_wdata, .ext_rdata_ff(ext_rdata), .be_active(act[2]),
        .wr_active(act[1]), .rd_active(act[0]), .be_is_addr(is_addr[2]),
        .wr_is_addr(is_addr[1]), .rd_is_addr(is_addr[0]), .be_addr(abit[2]),
        .wr_addr(abit[1]), .rd_addr(abit[0]), .byte_enable_pin(be_pin),
        .write_strobe_pin(wr_pin), .enable_strobe_pin(en_pin), .read_strobe_pin(rd_pin), .irq);

    ext_master i_ext_master (.mclk, .ext_rdata_ff(ext_rdata), .ext_sel, .ext_wr, .ext_rd,
        .ext_wdata);

    task reg_write(input logic [3:0] a, input logic [15:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task reg_read(input logic [3:0] a, output logic [15:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    task chk_stat(input logic [15:0] e);
        reg_read(`ADDR_BUFFER_STATUS, d);
        `CHK("status", e, d)
    endtask

    task end_of_test;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        chk_stat(16'h008F);
        for (int i = 0; i < 4; i++) i_ext_master.put(i[1:0], 8'h10 + i[7:0]);
        chk_stat(16'h8F8F);
        i_ext_master.put(2'h2, 8'hEE);
        chk_stat(16'hCF8F);
        reg_read(4'h6, d);
        `CHK("in buf 2", 16'h0012, d)
        chk_stat(16'h4B8F);
        `CHK("irq masked", 1'b0, irq)
        reg_write(`ADDR_IRQ_MASK, 16'h0003);
        #1 `CHK("irq on", 1'b1, irq)
        reg_write(`ADDR_BUFFER_STATUS, 16'h0000);
        reg_write(`ADDR_IRQ_STATUS, 16'h0001);
        chk_stat(16'h0B8F);
        `CHK("irq off", 1'b0, irq)
        reg_write(4'h9, 16'h00A5);
        chk_stat(16'h0B0D);
        i_ext_master.get(2'h1, b);
        `CHK("out buf 1", 8'hA5, b)
        chk_stat(16'h0B8F);
        i_ext_master.get(2'h3, b);
        chk_stat(16'h0BCF);
        `CHK("irq underflow", 1'b1, irq)
        reg_write(`ADDR_BUFFER_STATUS, 16'h0000);
        reg_write(`ADDR_IRQ_STATUS, 16'h0002);
        reg_read(4'h4, d);
        reg_read(4'h5, d);
        reg_read(4'h7, d);
        chk_stat(16'h008F);
        `CHK("irq cleared", 1'b0, irq)
        reg_write(4'hF, 16'hFFFF);
        reg_read(4'hF, d);
        `CHK("unmapped", 16'h0000, d)
        for (int p = 0; p < 8; p++) begin
            reg_write(`ADDR_CONTROL_POLARITY, {13'h0000, p[2:0]});
            reg_read(`ADDR_CONTROL_POLARITY, d);
            `CHK("control", {13'h0000, p[2:0]}, d)
            for (int m = 0; m < 4; m++) begin
                for (int a = 0; a < 2; a++) begin
                    @(posedge mclk);
                    port_mode_select <= m[1:0];
                    act <= {3{a[0]}};
                    is_addr <= 3'h0;
                    @(posedge mclk);
                    #1 `CHK("be pin", a[0] ~^ p[2], be_pin)
                    if (m == 3) begin
                        `CHK("en pin", a[0] ~^ p[1], en_pin)
                        `CHK("wr idle", ~p[1], wr_pin)
                    end else begin
                        `CHK("wr pin", a[0] ~^ p[1], wr_pin)
                        `CHK("en idle", ~p[1], en_pin)
                    end
                    `CHK("rd pin", a[0] ~^ p[0], rd_pin)
                    @(posedge mclk);
                    is_addr <= 3'h7;
                    abit <= {3{a[0]}};
                    act <= {3{~a[0]}};
                    @(posedge mclk);
                    #1 `CHK("be addr", a[0], be_pin)
                    `CHK("wr addr", a[0], (m == 3) ? en_pin : wr_pin)
                    `CHK("rd addr", a[0], rd_pin)
                end
            end
        end
        end_of_test();
    end

    initial begin
        #(100 * 20000);
        errors++;
        end_of_test();
    end
endmodule

bind parallel_port_status_polarity port_monitor i_port_monitor (.mclk, .rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_ff, .port_mode_select, .be_active, .wr_active,
    .rd_active, .be_is_addr, .wr_is_addr, .rd_is_addr, .be_addr, .wr_addr, .rd_addr,
    .byte_enable_pin, .write_strobe_pin, .enable_strobe_pin, .read_strobe_pin);
